// [rtl/iex_pkg.sv]
// constants and types for the instruction execution subset
// assumes a single core clock and a decoder that presents one instruction per request
//
// Overview of operation
// - rotate left through link: old link into bit 0, bit 7 to link
// - rotate right through link: old link into bit 7, bit 0 to link
// - target_select 0 writes accumulator, 1 writes the addressed register; literal subtract and literal xor always write accumulator
// - halt clears watchdog counter and its prescaler
// - halt clears powerdown flag and sets timeout flag
// - halt stops execution until a wake event
// - subroutine exit pops stack into program counter, two cycles, no flags
// - literal minus accumulator into accumulator, updates link, half carry, null
// - register minus accumulator to destination, updates link, half carry, null
// - nibble exchange swaps halves to destination, flags unchanged
// - literal xor accumulator into accumulator, only null flag
// - register xor accumulator to destination, only null flag
package iex_pkg;
    localparam int IEX_DW = 8;
    localparam int IEX_PCW = 13;
    localparam logic [7:0] IEX_ACC_RST = 8'h00;
    localparam logic [1:0] IEX_RET_CYCLES = 2'h2;
    localparam int IEX_NIB_LO = 0;
    localparam int IEX_NIB_HI = 4;
    // status layout on the flag ports
    localparam int IEX_ST_LINK = 0;
    localparam int IEX_ST_HALF = 1;
    localparam int IEX_ST_NULL = 2;

    typedef enum logic [3:0] {
        IEX_OP_NONE = 4'h0,
        IEX_OP_ROTL = 4'h1,
        IEX_OP_ROTR = 4'h2,
        IEX_OP_LSUB = 4'h3,
        IEX_OP_RSUB = 4'h4,
        IEX_OP_NSWAP = 4'h5,
        IEX_OP_LXOR = 4'h6,
        IEX_OP_RXOR = 4'h7,
        IEX_OP_EXIT = 4'h8,
        IEX_OP_HALT = 4'h9
    } iex_op_t;

    typedef enum logic [1:0] {
        IEX_ST_RUN = 2'b00,
        IEX_ST_RET2 = 2'b01,
        IEX_ST_HALTED = 2'b10
    } iex_state_t;
endpackage

// [rtl/iex_alu.sv]
// combinational result and flag logic for the subset
// assumes operands are stable while the request is presented
`timescale 1ns/10ps
module iex_alu
    import iex_pkg::*;
(
    input wire iex_op_t i_op,
    input wire logic [7:0] i_acc,
    input wire logic [7:0] i_operand,
    input wire logic [7:0] i_literal,
    input wire logic i_link,
    output logic [7:0] o_result,
    output logic o_link,
    output logic o_half,
    output logic o_link_we,
    output logic o_half_we,
    output logic o_null_we
);
    logic [8:0] diff;
    logic [4:0] hdiff;
    logic [7:0] minu;

    always_comb begin
        minu = (i_op == IEX_OP_LSUB) ? i_literal : i_operand;
        diff = {1'b0, minu} + {1'b0, ~i_acc} + 9'h001;
        hdiff = {1'b0, minu[3:0]} + {1'b0, ~i_acc[3:0]} + 5'h01;
        o_result = 8'h00;
        o_link = i_link;
        o_half = 1'b0;
        o_link_we = 1'b0;
        o_half_we = 1'b0;
        o_null_we = 1'b0;
        case (i_op)
            IEX_OP_ROTL: begin
                o_result = {i_operand[6:0], i_link};
                o_link = i_operand[7];
                o_link_we = 1'b1;
            end
            IEX_OP_ROTR: begin
                o_result = {i_link, i_operand[7:1]};
                o_link = i_operand[0];
                o_link_we = 1'b1;
            end
            IEX_OP_LSUB, IEX_OP_RSUB: begin
                o_result = diff[7:0];
                o_link = diff[8];
                o_half = hdiff[4];
                o_link_we = 1'b1;
                o_half_we = 1'b1;
                o_null_we = 1'b1;
            end
            IEX_OP_NSWAP: begin
                o_result = {i_operand[IEX_NIB_LO +: 4], i_operand[IEX_NIB_HI +: 4]};
            end
            IEX_OP_LXOR: begin
                o_result = i_acc ^ i_literal;
                o_null_we = 1'b1;
            end
            IEX_OP_RXOR: begin
                o_result = i_acc ^ i_operand;
                o_null_we = 1'b1;
            end
            default: begin
                o_result = 8'h00;
            end
        endcase
    end
endmodule // iex_alu

// [rtl/iex_exec.sv]
// execution unit for rotate, subtract, swap, xor, subroutine exit and halt
// assumes the decoder holds i_req one cycle per instruction and honours o_busy
`timescale 1ns/10ps
module iex_exec
    import iex_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_req,
    input wire iex_op_t i_op,
    input wire logic i_target_select,
    input wire logic [6:0] i_reg_addr,
    input wire logic [7:0] i_operand,
    input wire logic [7:0] i_literal,
    input wire logic [IEX_PCW-1:0] i_stack_head,
    input wire logic i_wake,
    output logic [7:0] o_acc,
    output logic o_link,
    output logic o_half_carry,
    output logic o_result_null_flag,
    output logic o_timeout_flag,
    output logic o_powerdown_flag,
    output logic o_reg_we,
    output logic [6:0] o_reg_addr,
    output logic [7:0] o_reg_wdata,
    output logic o_stack_pop,
    output logic o_pc_load,
    output logic [IEX_PCW-1:0] o_pc,
    output logic o_watchdog_clear,
    output logic o_halted,
    output logic o_busy
);
    typedef struct packed {
        iex_state_t st;
        logic [7:0] acc;
        logic link;
        logic half;
        logic nul;
        logic tmo_f;
        logic pdn_f;
        logic reg_we;
        logic [6:0] reg_addr;
        logic [7:0] reg_wdata;
        logic pop;
        logic pc_load;
        logic [IEX_PCW-1:0] pc;
        logic wdog_clr;
        logic halted;
        logic busy;
    } iex_regs_t;

    iex_regs_t s_reg;
    iex_regs_t s_next;
    logic [7:0] alu_res;
    logic alu_link;
    logic alu_half;
    logic link_we;
    logic half_we;
    logic null_we;
    logic to_acc;

    iex_alu u_alu (
        .i_op(i_op),
        .i_acc(s_reg.acc),
        .i_operand(i_operand),
        .i_literal(i_literal),
        .i_link(s_reg.link),
        .o_result(alu_res),
        .o_link(alu_link),
        .o_half(alu_half),
        .o_link_we(link_we),
        .o_half_we(half_we),
        .o_null_we(null_we)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_next = s_reg;
        s_next.reg_we = 1'b0;
        s_next.pop = 1'b0;
        s_next.pc_load = 1'b0;
        s_next.wdog_clr = 1'b0;
        to_acc = (i_op == IEX_OP_LSUB) || (i_op == IEX_OP_LXOR) || !i_target_select;
        case (s_reg.st)
            IEX_ST_RUN: begin
                if (i_req) begin
                    case (i_op)
                        IEX_OP_EXIT: begin
                            s_next.pop = 1'b1;
                            s_next.pc_load = 1'b1;
                            s_next.pc = i_stack_head;
                            s_next.busy = 1'b1;
                            s_next.st = IEX_ST_RET2;
                        end
                        IEX_OP_HALT: begin
                            s_next.wdog_clr = 1'b1;
                            s_next.tmo_f = 1'b1;
                            s_next.pdn_f = 1'b0;
                            s_next.halted = 1'b1;
                            s_next.busy = 1'b1;
                            s_next.st = IEX_ST_HALTED;
                        end
                        IEX_OP_NONE: begin
                            s_next.st = IEX_ST_RUN;
                        end
                        default: begin
                            if (to_acc) begin
                                s_next.acc = alu_res;
                            end else begin
                                s_next.reg_we = 1'b1;
                                s_next.reg_addr = i_reg_addr;
                                s_next.reg_wdata = alu_res;
                            end
                            if (link_we) s_next.link = alu_link;
                            if (half_we) s_next.half = alu_half;
                            if (null_we) s_next.nul = (alu_res == 8'h00);
                        end
                    endcase
                end
            end
            IEX_ST_RET2: begin
                s_next.busy = 1'b0;
                s_next.st = IEX_ST_RUN;
            end
            IEX_ST_HALTED: begin
                if (i_wake) begin
                    s_next.halted = 1'b0;
                    s_next.busy = 1'b0;
                    s_next.st = IEX_ST_RUN;
                end
            end
            default: begin
                s_next.st = IEX_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_reg <= '{st: IEX_ST_RUN, acc: IEX_ACC_RST, tmo_f: 1'b1, pdn_f: 1'b1, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign o_acc = s_reg.acc;
    assign o_link = s_reg.link;
    assign o_half_carry = s_reg.half;
    assign o_result_null_flag = s_reg.nul;
    assign o_timeout_flag = s_reg.tmo_f;
    assign o_powerdown_flag = s_reg.pdn_f;
    assign o_reg_we = s_reg.reg_we;
    assign o_reg_addr = s_reg.reg_addr;
    assign o_reg_wdata = s_reg.reg_wdata;
    assign o_stack_pop = s_reg.pop;
    assign o_pc_load = s_reg.pc_load;
    assign o_pc = s_reg.pc;
    assign o_watchdog_clear = s_reg.wdog_clr;
    assign o_halted = s_reg.halted;
    assign o_busy = s_reg.busy;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    wire run_req = i_req && s_reg.st == IEX_ST_RUN;

    rot_left_a: assert property (run_req && i_op == IEX_OP_ROTL && !i_target_select |=>
        o_acc == {$past(i_operand[6:0]), $past(o_link)} && o_link == $past(i_operand[7]))
        else $error("rotate left result wrong");
    rot_right_a: assert property (run_req && i_op == IEX_OP_ROTR && !i_target_select |=>
        o_acc == {$past(o_link), $past(i_operand[7:1])} && o_link == $past(i_operand[0]))
        else $error("rotate right result wrong");
    rot_flags_a: assert property (run_req && (i_op == IEX_OP_ROTL || i_op == IEX_OP_ROTR) |=>
        $stable(o_half_carry) && $stable(o_result_null_flag))
        else $error("rotate changed other flags");
    dest_reg_a: assert property (run_req && i_op == IEX_OP_RXOR && i_target_select |=>
        o_reg_we && o_reg_wdata == $past(i_operand ^ o_acc) && $stable(o_acc))
        else $error("register destination not written");
    dest_acc_a: assert property (run_req && i_op == IEX_OP_RSUB && !i_target_select |=>
        !o_reg_we && o_acc == 8'($past(i_operand) - $past(o_acc)))
        else $error("accumulator destination not written");
    halt_wdog_a: assert property (run_req && i_op == IEX_OP_HALT |=>
        o_watchdog_clear ##1 !o_watchdog_clear)
        else $error("watchdog clear missing");
    halt_flags_a: assert property (run_req && i_op == IEX_OP_HALT |=>
        o_timeout_flag && !o_powerdown_flag)
        else $error("halt flags wrong");
    halt_stay_a: assert property (o_halted && !i_wake |=> o_halted && $stable(o_acc))
        else $error("left halt without wake");
    halt_refuse_a: assert property (o_halted |=> !o_reg_we && !o_pc_load && !o_stack_pop)
        else $error("work done while halted");
    ret_two_a: assert property (run_req && i_op == IEX_OP_EXIT |=>
        o_pc_load && o_stack_pop && o_busy && o_pc == $past(i_stack_head) ##1 !o_busy && !o_pc_load)
        else $error("return timing wrong");
    ret_flags_a: assert property (run_req && i_op == IEX_OP_EXIT |=>
        $stable(o_link) && $stable(o_half_carry) && $stable(o_result_null_flag))
        else $error("return changed flags");
    ret_dead_a: assert property (s_reg.st == IEX_ST_RET2 |=> !o_busy && $stable(o_acc) && !o_reg_we)
        else $error("request taken in dead cycle");
    lsub_val_a: assert property (run_req && i_op == IEX_OP_LSUB |=>
        o_acc == 8'($past(i_literal) - $past(o_acc)) && o_link == ($past(i_literal) >= $past(o_acc)))
        else $error("literal subtract wrong");
    rsub_half_a: assert property (run_req && i_op == IEX_OP_RSUB |=>
        o_half_carry == ($past(i_operand[3:0]) >= $past(o_acc[3:0])))
        else $error("half carry wrong");
    swap_flag_a: assert property (run_req && i_op == IEX_OP_NSWAP && !i_target_select |=>
        o_acc == {$past(i_operand[3:0]), $past(i_operand[7:4])} && $stable(o_result_null_flag))
        else $error("nibble exchange wrong");
    lxor_null_a: assert property (run_req && i_op == IEX_OP_LXOR |=>
        o_acc == $past(i_literal ^ o_acc) && o_result_null_flag == (o_acc == 8'h00) && $stable(o_link))
        else $error("xor null flag wrong");
    rxor_null_a: assert property (run_req && i_op == IEX_OP_RXOR |=>
        o_result_null_flag == ($past(i_operand ^ o_acc) == 8'h00) && $stable(o_link) && $stable(o_half_carry))
        else $error("register xor flags wrong");

    // main scenarios: return, halt and wake, zero result, refused request, register destination
    ret_c: cover property (run_req && i_op == IEX_OP_EXIT ##2 run_req);
    halt_c: cover property (run_req && i_op == IEX_OP_HALT ##[1:20] i_wake);
    sub_zero_c: cover property (run_req && i_op == IEX_OP_RSUB ##1 o_result_null_flag && o_link);
    ret_dead_c: cover property (s_reg.st == IEX_ST_RET2 && i_req);
    reg_dest_c: cover property (run_req && i_op == IEX_OP_ROTR && i_target_select);
endmodule // iex_exec

// [dv/iex_core_model.sv]
// partner model: register file and return stack beside the execution unit
// assumes writes and pops arrive as one-cycle pulses on the core clock
`timescale 1ns/10ps
module iex_core_model
    import iex_pkg::*;
(
    input wire logic i_mclk,
    input wire logic [6:0] i_raddr,
    input wire logic i_we,
    input wire logic [6:0] i_waddr,
    input wire logic [7:0] i_wdata,
    input wire logic i_pop,
    output logic [7:0] o_rdata,
    output logic [IEX_PCW-1:0] o_head
);
    logic [7:0] mem [128];
    logic [IEX_PCW-1:0] stk [4];
    logic [1:0] sp = 2'h3;
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i * 37);
        end
        stk = '{13'h0123, 13'h1ABC, 13'h0F0F, 13'h1555};
    end
    assign o_rdata = mem[i_raddr];
    assign o_head = stk[sp];
    always @(posedge i_mclk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        if (i_pop) begin
            sp <= sp - 2'h1;
        end
    end
endmodule // iex_core_model

// [dv/instr_exec_subset_test.sv]
// self-checking bench for the execution unit
// assumes results appear just after the taking edge
`timescale 1ns/10ps
module instr_exec_subset_test;
    import iex_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    iex_op_t op = IEX_OP_NONE;
    logic ts = 1'b0;
    logic [6:0] addr = 7'h00;
    logic [7:0] lit = 8'h00;
    logic wake = 1'b0;
    logic [7:0] opnd, acc, rwd, acc_m;
    logic [6:0] raddr;
    logic [IEX_PCW-1:0] head, pc;
    logic link, half, nul, tmo, pdn, rwe, pop, pcl, wdc, halted, busy, lk_m, hc_m, nz_m;
    int error_cnt = 0;
    int compares = 0;
    always #20 clk = ~clk;
    iex_exec DUT (.i_mclk(clk), .i_sys_rst(rst), .i_req(req), .i_op(op), .i_target_select(ts),
        .i_reg_addr(addr), .i_operand(opnd), .i_literal(lit), .i_stack_head(head), .i_wake(wake),
        .o_acc(acc), .o_link(link), .o_half_carry(half), .o_result_null_flag(nul),
        .o_timeout_flag(tmo), .o_powerdown_flag(pdn), .o_reg_we(rwe), .o_reg_addr(raddr),
        .o_reg_wdata(rwd), .o_stack_pop(pop), .o_pc_load(pcl), .o_pc(pc), .o_watchdog_clear(wdc),
        .o_halted(halted), .o_busy(busy));
    iex_core_model u_rf (.i_mclk(clk), .i_raddr(addr), .i_we(rwe), .i_waddr(raddr),
        .i_wdata(rwd), .i_pop(pop), .o_rdata(opnd), .o_head(head));
    ////////////////////////////////////////
    task automatic chk_bit(string nm, logic e, logic g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_val(string nm, logic [15:0] e, logic [15:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic send(iex_op_t o, logic t, logic [6:0] a, logic [7:0] l);
        @(posedge clk);
        op <= o;
        ts <= t;
        addr <= a;
        lit <= l;
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        #1;
    endtask
    // one operation; expected result worked out from the operand used
    task automatic do_op(iex_op_t o, logic t, logic [6:0] a, logic [7:0] l);
        logic [7:0] v, r;
        logic lk, hc, wa, lo;
        send(o, t, a, l);
        lo = o == IEX_OP_LSUB || o == IEX_OP_LXOR;
        v = lo ? l : u_rf.mem[a];
        wa = lo || t == 1'b0;
        lk = lk_m;
        hc = hc_m;
        case (o)
            IEX_OP_ROTL: {lk, r} = {v, lk_m};
            IEX_OP_ROTR: {r, lk} = {lk_m, v};
            IEX_OP_LSUB, IEX_OP_RSUB: begin
                r = v - acc_m;
                lk = v >= acc_m;
                hc = v[3:0] >= acc_m[3:0];
            end
            IEX_OP_NSWAP: r = {v[3:0], v[7:4]};
            default: r = v ^ acc_m;
        endcase
        if (o != IEX_OP_ROTL && o != IEX_OP_ROTR && o != IEX_OP_NSWAP) begin
            nz_m = r == 8'h00;
        end
        if (wa) begin
            acc_m = r;
        end else begin
            chk_val("reg_wdata", 16'(r), 16'(rwd));
            chk_val("reg_addr", 16'(a), 16'(raddr));
        end
        lk_m = lk;
        hc_m = hc;
        chk_bit("reg_we", !wa, rwe);
        chk_val("acc", 16'(acc_m), 16'(acc));
        chk_bit("link", lk_m, link);
        chk_bit("half", hc_m, half);
        chk_bit("null", nz_m, nul);
    endtask
    task automatic t_rot;
        do_op(IEX_OP_ROTL, 1'b0, 7'h05, 8'h00);
        do_op(IEX_OP_ROTR, 1'b1, 7'h05, 8'h00);
        do_op(IEX_OP_ROTL, 1'b1, 7'h05, 8'h00);
        do_op(IEX_OP_ROTR, 1'b0, 7'h0C, 8'h00);
        $display("test rot done");
    endtask
    task automatic t_arith;
        do_op(IEX_OP_LSUB, 1'b0, 7'h00, acc_m);
        do_op(IEX_OP_LXOR, 1'b1, 7'h00, 8'h18);
        do_op(IEX_OP_LSUB, 1'b0, 7'h00, 8'h07);
        do_op(IEX_OP_RSUB, 1'b1, 7'h09, 8'h00);
        do_op(IEX_OP_RSUB, 1'b0, 7'h00, 8'h00);
        do_op(IEX_OP_LSUB, 1'b0, 7'h00, 8'hFF);
        $display("test arith done");
    endtask
    task automatic t_logic;
        do_op(IEX_OP_LXOR, 1'b0, 7'h00, acc_m);
        do_op(IEX_OP_NSWAP, 1'b0, 7'h05, 8'h00);
        do_op(IEX_OP_NSWAP, 1'b1, 7'h0A, 8'h00);
        do_op(IEX_OP_RXOR, 1'b1, 7'h03, 8'h00);
        do_op(IEX_OP_RXOR, 1'b0, 7'h0B, 8'h00);
        $display("test logic done");
    endtask
    // an xor follows the exit at once and is held through the dead cycle: it must be taken once only
    task automatic t_exit;
        logic [IEX_PCW-1:0] h;
        h = head;
        @(posedge clk);
        op <= IEX_OP_EXIT;
        req <= 1'b1;
        @(posedge clk);
        op <= IEX_OP_LXOR;
        lit <= 8'hFF;
        #1;
        chk_bit("pc_load", 1'b1, pcl);
        chk_bit("stack_pop", 1'b1, pop);
        chk_val("pc", 16'(h), 16'(pc));
        chk_bit("busy", 1'b1, busy);
        chk_bit("link", lk_m, link);
        chk_bit("null", nz_m, nul);
        repeat (2) @(posedge clk);
        req <= 1'b0;
        #1;
        acc_m = acc_m ^ 8'hFF;
        nz_m = acc_m == 8'h00;
        chk_val("acc", 16'(acc_m), 16'(acc));
        chk_bit("null", nz_m, nul);
        chk_bit("pc_load", 1'b0, pcl);
        chk_bit("busy", 1'b0, busy);
        $display("test exit done");
    endtask
    task automatic t_halt;
        send(IEX_OP_HALT, 1'b0, 7'h00, 8'h00);
        chk_bit("watchdog_clear", 1'b1, wdc);
        chk_bit("timeout", 1'b1, tmo);
        chk_bit("powerdown", 1'b0, pdn);
        chk_bit("halted", 1'b1, halted);
        @(posedge clk);
        op <= IEX_OP_LXOR;
        lit <= 8'h5A;
        req <= 1'b1;
        repeat (4) @(posedge clk);
        req <= 1'b0;
        wake <= 1'b1;
        #1;
        chk_bit("watchdog_clear", 1'b0, wdc);
        chk_val("acc", 16'(acc_m), 16'(acc));
        chk_bit("busy", 1'b1, busy);
        @(posedge clk);
        wake <= 1'b0;
        #1;
        chk_bit("halted", 1'b0, halted);
        chk_bit("busy", 1'b0, busy);
        chk_bit("powerdown", 1'b0, pdn);
        chk_bit("timeout", 1'b1, tmo);
        do_op(IEX_OP_LXOR, 1'b0, 7'h00, 8'h3C);
        $display("test halt done");
    endtask
    initial begin
        #400000;
        error_cnt++;
        end_sim;
    end
    initial begin
        acc_m = 8'h00;
        lk_m = 1'b0;
        hc_m = 1'b0;
        nz_m = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk_bit("timeout", 1'b1, tmo);
        chk_bit("powerdown", 1'b1, pdn);
        chk_bit("busy", 1'b0, busy);
        t_rot;
        t_arith;
        t_logic;
        t_exit;
        t_exit;
        t_halt;
        end_sim;
    end
endmodule // instr_exec_subset_test
